// ==== common/gtc_pkg.sv ====
package gtc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes and stream carriers.
   localparam int PAY_DEPTH = 64;
   localparam int PAY_AW = 6;
   localparam int N_RW = 9;
   localparam int N_RO = 3;

   typedef struct packed {
      logic [15:0] data;
      logic last;
   } gtc_beat_s;

   typedef struct packed {
      logic [15:0] data;
      logic last;
      logic err;
   } gtc_rx_beat_s;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } gtc_apb_req_s;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ETYPE = 8'h04;
   localparam logic [7:0] OFS_KEY = 8'h08;
   localparam logic [7:0] OFS_L2_HI = 8'h0c;
   localparam logic [7:0] OFS_L2_LO = 8'h10;
   localparam logic [7:0] OFS_L3_0 = 8'h14;
   localparam logic [7:0] OFS_TX_SEQ = 8'h24;
   localparam logic [7:0] OFS_RX_DROP = 8'h28;
   localparam logic [7:0] OFS_RX_EXP = 8'h2c;
   localparam logic [5:0] IDX_LAST = 6'h0b;
   localparam logic [5:0] IDX_RW_LAST = 6'h08;

   localparam int CTRL_CSUM = 0;
   localparam int CTRL_KEY = 1;
   localparam int CTRL_SEQ = 2;
   localparam int CTRL_V6 = 3;
   localparam int CTRL_LEGACY = 4;

   localparam logic [N_RW-1:0][31:0] RW_RST = {
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0800,
      32'h0000_0000};

   ////////////////////////////////////////////////////////////////////////////
   // Header layout and segment lengths in 16-bit words.
   localparam logic [15:0] HDR_RSV_MASK = 16'h7c00;
   localparam logic [15:0] HDR_VER_MASK = 16'h0007;
   localparam int HDR_C_BIT = 15;
   localparam int HDR_K_BIT = 13;
   localparam int HDR_S_BIT = 12;
   localparam logic [15:0] CSUM_GOOD = 16'hffff;
   localparam logic [6:0] L2_WORDS = 7'h03;
   localparam logic [6:0] L3_V4_WORDS = 7'h02;
   localparam logic [6:0] L3_V6_WORDS = 7'h08;
   localparam logic [6:0] PAIR_WORDS = 7'h02;

   function automatic logic [15:0] gtc_ocadd(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction

endpackage

// ==== rtl/gtc_oc_acc.sv ====
module gtc_oc_acc (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic clr_in,
   input wire logic add_in,
   input wire logic [15:0] word_in,
   output logic [15:0] sum_out
);
   import gtc_pkg::*;

   logic [15:0] sum_reg;

   // End-around carry keeps the running sum a true one's complement sum.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sum_reg <= 16'h0000;
      end else if (clr_in) begin
         sum_reg <= 16'h0000;
      end else if (add_in) begin
         sum_reg <= gtc_ocadd(sum_reg, word_in);
      end
   end

   assign sum_out = sum_reg;
endmodule

// ==== rtl/gtc_regs.sv ====
module gtc_regs (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input gtc_pkg::gtc_apb_req_s apb_req_in,
   input wire logic [gtc_pkg::N_RO-1:0][31:0] ro_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [gtc_pkg::N_RW-1:0][31:0] cfg_out
);
   import gtc_pkg::*;

   logic [N_RW-1:0][31:0] cfg_reg;
   logic [31:0] prdata_reg;
   wire logic [5:0] idx = apb_req_in.paddr[7:2];
   wire logic mapped = (apb_req_in.paddr[1:0] == 2'b00) && (idx <= IDX_LAST);
   wire logic access = apb_req_in.psel && apb_req_in.penable;
   wire logic setup = apb_req_in.psel && !apb_req_in.penable;
   wire logic wr_ok = access && apb_req_in.pwrite && mapped && (idx <= IDX_RW_LAST);
   wire logic [31:0] rd_word = !mapped ? 32'h0000_0000 :
      (idx <= IDX_RW_LAST) ? cfg_reg[idx[3:0]] : ro_in[idx[1:0] - 2'h1];

   genvar i;
   generate
      for (i = 0; i < N_RW; i++) begin : g_rw
         always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               cfg_reg[i] <= RW_RST[i];
            end else if (wr_ok && idx == 6'(i)) begin
               cfg_reg[i] <= apb_req_in.pwdata;
            end
         end
      end
   endgenerate

   // Read data is captured in the setup cycle so it comes from a flop.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup) begin
         prdata_reg <= rd_word;
      end
   end

   assign prdata_out = prdata_reg;
   assign pready_out = 1'b1;
   assign pslverr_out = access && !mapped;
   assign cfg_out = cfg_reg;
endmodule

// ==== rtl/gtc_gre_codec.sv ====
// The register offsets and the APB interface to the registers are this design's own decisions.
module gtc_gre_codec (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input gtc_pkg::gtc_apb_req_s apb_req_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic pl_in_valid_in,
   input gtc_pkg::gtc_beat_s pl_in_beat_in,
   output logic pl_in_ready_out,
   output logic tn_out_valid_out,
   output gtc_pkg::gtc_beat_s tn_out_beat_out,
   input wire logic tn_out_ready_in,
   input wire logic tn_in_valid_in,
   input gtc_pkg::gtc_beat_s tn_in_beat_in,
   output logic tn_in_ready_out,
   output logic pl_out_valid_out,
   output gtc_pkg::gtc_rx_beat_s pl_out_beat_out,
   input wire logic pl_out_ready_in
);
   import gtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [N_RW-1:0][31:0] cfg;
   logic [31:0] tx_seq_reg;
   logic [31:0] rx_drop_reg;
   logic [31:0] rx_exp_reg;

   gtc_regs u_regs (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .apb_req_in(apb_req_in),
      .ro_in({rx_exp_reg, rx_drop_reg, tx_seq_reg}),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .cfg_out(cfg)
   );

   wire logic [31:0] ctrl = cfg[0];

   ////////////////////////////////////////////////////////////////////////////
   // Encapsulation. The whole payload is held first because the checksum
   // must be known before the header goes out; payloads above the depth
   // are truncated, which trades length for a small fixed memory.
   typedef enum logic [7:0] {
      TX_LOAD = 8'h01, TX_L2 = 8'h02, TX_L3 = 8'h04, TX_GRE = 8'h08,
      TX_CS = 8'h10, TX_KEY = 8'h20, TX_SEQ = 8'h40, TX_PAY = 8'h80
   } gtc_tx_e;

   gtc_tx_e tx_reg, tx_next;
   logic [15:0] pay_mem [0:PAY_DEPTH-1];
   logic [6:0] tcnt_reg;
   logic [6:0] tlen_reg;
   logic c_reg, k_reg, s_reg, v6_reg;
   logic [31:0] key_reg;
   logic [15:0] etype_reg;
   logic tvalid_reg;
   gtc_beat_s tbeat_reg;
   logic [15:0] pay_sum;
   logic [15:0] tword;
   logic [6:0] seg_len;

   wire logic ld_acc = (tx_reg == TX_LOAD) && pl_in_valid_in;
   wire logic ld_store = ld_acc && !tcnt_reg[6];
   wire logic ld_end = ld_acc && pl_in_beat_in.last;
   wire logic tx_adv = (tx_reg != TX_LOAD) && (!tvalid_reg || tn_out_ready_in);
   wire logic seg_end = tx_adv && (tcnt_reg == seg_len - 7'h01);
   wire logic pkt_end = seg_end && (tx_reg == TX_PAY);
   wire logic [15:0] flags_w = {c_reg, 1'b0, k_reg, s_reg, 12'h000};
   wire logic [15:0] key_sum = k_reg ? gtc_ocadd(key_reg[31:16], key_reg[15:0]) : 16'h0000;
   wire logic [15:0] seq_sum = s_reg ? gtc_ocadd(tx_seq_reg[31:16], tx_seq_reg[15:0]) : 16'h0000;
   wire logic [15:0] hdr_sum = gtc_ocadd(gtc_ocadd(flags_w, etype_reg),
      gtc_ocadd(key_sum, seq_sum));
   wire logic [15:0] csum = ~gtc_ocadd(hdr_sum, pay_sum);
   wire gtc_tx_e after_key = s_reg ? TX_SEQ : TX_PAY;
   wire gtc_tx_e after_cs = k_reg ? TX_KEY : after_key;
   wire gtc_tx_e after_gre = c_reg ? TX_CS : after_cs;
   wire logic [31:0] l3_word = cfg[5 + 32'(tcnt_reg[2:1])];

   gtc_oc_acc u_tx_acc (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .clr_in(pkt_end),
      .add_in(ld_store),
      .word_in(pl_in_beat_in.data),
      .sum_out(pay_sum)
   );

   always_comb begin
      seg_len = PAIR_WORDS;
      tword = 16'h0000;
      tx_next = tx_reg;
      unique case (tx_reg)
         TX_LOAD: begin
            seg_len = tlen_reg;
            if (ld_end) tx_next = TX_L2;
         end
         TX_L2: begin
            seg_len = L2_WORDS;
            tword = (tcnt_reg == 7'h00) ? cfg[3][15:0] :
               (tcnt_reg == 7'h01) ? cfg[4][31:16] : cfg[4][15:0];
            if (seg_end) tx_next = TX_L3;
         end
         TX_L3: begin
            seg_len = v6_reg ? L3_V6_WORDS : L3_V4_WORDS;
            tword = tcnt_reg[0] ? l3_word[15:0] : l3_word[31:16];
            if (seg_end) tx_next = TX_GRE;
         end
         TX_GRE: begin
            tword = tcnt_reg[0] ? etype_reg : flags_w;
            if (seg_end) tx_next = after_gre;
         end
         TX_CS: begin
            tword = tcnt_reg[0] ? 16'h0000 : csum;
            if (seg_end) tx_next = after_cs;
         end
         TX_KEY: begin
            tword = tcnt_reg[0] ? key_reg[15:0] : key_reg[31:16];
            if (seg_end) tx_next = after_key;
         end
         TX_SEQ: begin
            tword = tcnt_reg[0] ? tx_seq_reg[15:0] : tx_seq_reg[31:16];
            if (seg_end) tx_next = TX_PAY;
         end
         TX_PAY: begin
            seg_len = tlen_reg;
            tword = pay_mem[tcnt_reg[5:0]];
            if (seg_end) tx_next = TX_LOAD;
         end
         default: tx_next = TX_LOAD;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (ld_store) pay_mem[tcnt_reg[5:0]] <= pl_in_beat_in.data;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_reg <= TX_LOAD;
         tcnt_reg <= 7'h00;
         tlen_reg <= 7'h00;
      end else begin
         tx_reg <= tx_next;
         if (ld_end) tlen_reg <= tcnt_reg[6] ? tcnt_reg : tcnt_reg + 7'h01;
         if (ld_end || seg_end) tcnt_reg <= 7'h00;
         else if (ld_store || tx_adv) tcnt_reg <= tcnt_reg + 7'h01;
      end
   end

   // Flags, key and Ethertype are frozen per packet so software writes
   // cannot tear a GRE header that is already under way; L2 and L3 words are read live.
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {c_reg, k_reg, s_reg, v6_reg} <= 4'h0;
         key_reg <= 32'h0000_0000;
         etype_reg <= 16'h0000;
      end else if (ld_end) begin
         c_reg <= ctrl[CTRL_CSUM];
         k_reg <= ctrl[CTRL_KEY];
         s_reg <= ctrl[CTRL_SEQ];
         v6_reg <= ctrl[CTRL_V6];
         key_reg <= cfg[2];
         etype_reg <= cfg[1][15:0];
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_seq_reg <= 32'h0000_0000;
      end else if (pkt_end && s_reg) begin
         tx_seq_reg <= tx_seq_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tvalid_reg <= 1'b0;
         tbeat_reg <= '0;
      end else if (tx_adv) begin
         tvalid_reg <= 1'b1;
         tbeat_reg <= '{data: tword, last: pkt_end};
      end else if (tn_out_ready_in) begin
         tvalid_reg <= 1'b0;
      end
   end

   assign pl_in_ready_out = (tx_reg == TX_LOAD);
   assign tn_out_valid_out = tvalid_reg;
   assign tn_out_beat_out = tbeat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Decapsulation. Header arrives first, delivery header already removed.
   typedef enum logic [7:0] {
      RX_W0 = 8'h01, RX_ET = 8'h02, RX_CS = 8'h04, RX_RSV = 8'h08,
      RX_KEY = 8'h10, RX_SEQ = 8'h20, RX_PAY = 8'h40, RX_DROP = 8'h80
   } gtc_rx_e;

   gtc_rx_e rx_reg, rx_next;
   logic rc_reg, rk_reg, rs_reg, rhalf_reg;
   logic [15:0] rseq_hi_reg;
   logic pvalid_reg;
   gtc_rx_beat_s pbeat_reg;
   logic [15:0] rx_sum;

   wire logic [15:0] w = tn_in_beat_in.data;
   wire logic rx_acc = tn_in_valid_in && tn_in_ready_out;
   wire logic rx_last = rx_acc && tn_in_beat_in.last;
   wire logic w0_bad = ((w & HDR_RSV_MASK) != 16'h0000 && !ctrl[CTRL_LEGACY]) ||
      ((w & HDR_VER_MASK) != 16'h0000);
   wire logic [31:0] rseq = {rseq_hi_reg, w};
   wire logic [31:0] seq_gap = rseq - rx_exp_reg;
   wire logic seq_late = rs_reg && seq_gap[31];
   wire gtc_rx_e r_after_key = rs_reg ? RX_SEQ : RX_PAY;
   wire gtc_rx_e r_after_cs = rk_reg ? RX_KEY : r_after_key;
   wire logic hdr_state = (rx_reg != RX_PAY) && (rx_reg != RX_DROP);
   wire logic seq_done = rx_acc && (rx_reg == RX_SEQ) && rhalf_reg;
   wire logic drop_evt = rx_acc && ((rx_reg == RX_W0 && w0_bad) ||
      (seq_done && seq_late) || (hdr_state && tn_in_beat_in.last));
   wire logic sum_bad = rc_reg && (gtc_ocadd(rx_sum, w) != CSUM_GOOD);

   gtc_oc_acc u_rx_acc (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .clr_in(rx_last),
      .add_in(rx_acc),
      .word_in(w),
      .sum_out(rx_sum)
   );

   always_comb begin
      rx_next = rx_reg;
      if (rx_acc) begin
         unique case (rx_reg)
            RX_W0: rx_next = w0_bad ? RX_DROP : RX_ET;
            RX_ET: rx_next = rc_reg ? RX_CS : r_after_cs;
            RX_CS: rx_next = RX_RSV;
            RX_RSV: rx_next = r_after_cs;
            RX_KEY: rx_next = rhalf_reg ? r_after_key : RX_KEY;
            RX_SEQ: rx_next = !rhalf_reg ? RX_SEQ : seq_late ? RX_DROP : RX_PAY;
            RX_PAY: rx_next = RX_PAY;
            RX_DROP: rx_next = RX_DROP;
            default: rx_next = RX_W0;
         endcase
         if (tn_in_beat_in.last) rx_next = RX_W0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_reg <= RX_W0;
         {rc_reg, rk_reg, rs_reg, rhalf_reg} <= 4'h0;
         rseq_hi_reg <= 16'h0000;
         rx_exp_reg <= 32'h0000_0000;
         rx_drop_reg <= 32'h0000_0000;
      end else begin
         rx_reg <= rx_next;
         if (rx_acc && rx_reg == RX_W0) begin
            rc_reg <= w[HDR_C_BIT];
            rk_reg <= w[HDR_K_BIT];
            rs_reg <= w[HDR_S_BIT];
         end
         if (rx_acc && (rx_reg == RX_KEY || rx_reg == RX_SEQ)) rhalf_reg <= !rhalf_reg;
         if (rx_last) rhalf_reg <= 1'b0;
         if (rx_acc && rx_reg == RX_SEQ && !rhalf_reg) rseq_hi_reg <= w;
         if (seq_done && !seq_late) rx_exp_reg <= rseq + 32'h0000_0001;
         if (drop_evt) rx_drop_reg <= rx_drop_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pvalid_reg <= 1'b0;
         pbeat_reg <= '0;
      end else if (rx_acc && rx_reg == RX_PAY) begin
         pvalid_reg <= 1'b1;
         pbeat_reg <= '{data: w, last: tn_in_beat_in.last, err: sum_bad};
      end else if (pl_out_ready_in) begin
         pvalid_reg <= 1'b0;
      end
   end

   assign tn_in_ready_out = (rx_reg != RX_PAY) || !pvalid_reg || pl_out_ready_in;
   assign pl_out_valid_out = pvalid_reg;
   assign pl_out_beat_out = pbeat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   tx_rsv_zero_a: assert property (tx_adv && tx_reg == TX_CS && tcnt_reg[0] |=>
      tbeat_reg.data == 16'h0000) else $error("reserved halfword not zero");
   tx_flags_a: assert property (tx_adv && tx_reg == TX_GRE && !tcnt_reg[0] |=>
      (tbeat_reg.data & ~(16'h0001 << HDR_C_BIT) & ~(16'h0001 << HDR_K_BIT) &
      ~(16'h0001 << HDR_S_BIT)) == 16'h0000)
      else $error("version or reserved bits sent nonzero");
   tx_etype_a: assert property (tx_adv && tx_reg == TX_GRE && tcnt_reg[0] |=>
      tbeat_reg.data == $past(cfg[1][15:0], 2) || tbeat_reg.data == etype_reg)
      else $error("ethertype word wrong");
   tx_order_a: assert property (seg_end && tx_reg == TX_GRE && !c_reg && k_reg |=>
      tx_reg == TX_KEY) else $error("key word out of order");
   tx_seq_step_a: assert property (pkt_end && s_reg |=>
      tx_seq_reg == $past(tx_seq_reg) + 32'h0000_0001) else $error("sequence not stepped");
   rx_ver_drop_a: assert property (rx_acc && rx_reg == RX_W0 &&
      (w & HDR_VER_MASK) != 16'h0000 |=> rx_reg != RX_ET && rx_reg != RX_PAY)
      else $error("bad version accepted");
   rx_rsv_drop_a: assert property (rx_acc && rx_reg == RX_W0 && !ctrl[CTRL_LEGACY] &&
      (w & HDR_RSV_MASK) != 16'h0000 |=> rx_drop_reg == $past(rx_drop_reg) + 32'h0000_0001)
      else $error("reserved bits not dropped");
   rx_late_a: assert property (seq_done && seq_late && !tn_in_beat_in.last |=>
      rx_reg == RX_DROP ##1 !pvalid_reg || !$rose(pvalid_reg))
      else $error("late packet forwarded");
   rx_strip_a: assert property (rx_acc && rx_reg == RX_PAY |=>
      pvalid_reg && pbeat_reg.data == $past(w)) else $error("payload not forwarded");

   cv_tx_full_c: cover property (tx_reg == TX_SEQ && c_reg && k_reg);
   cv_rx_pay_c: cover property (pvalid_reg && pbeat_reg.last && !pbeat_reg.err);
   cv_rx_late_c: cover property (seq_done && seq_late);
endmodule

// ==== verification/gtc_peer.sv ====
module gtc_peer (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic stall_in,
   input wire logic out_valid_in,
   input gtc_pkg::gtc_beat_s out_beat_in,
   output logic out_ready_out,
   output logic in_valid_out,
   output gtc_pkg::gtc_beat_s in_beat_out,
   input wire logic in_ready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import gtc_pkg::*;

   gtc_beat_s rx_q[$];
   gtc_beat_s tx_q[$];

   initial begin
      out_ready_out = 1'b0;
      in_valid_out = 1'b0;
      in_beat_out = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Words leave in queue order, so the header order is whatever the bench built.
   always @(posedge sys_clk_in) begin
      if (out_valid_in && out_ready_out) begin
         rx_q.push_back(out_beat_in);
      end
      out_ready_out <= reset_n_in && !stall_in;
      if (!in_valid_out || in_ready_in) begin
         if (reset_n_in && !stall_in && tx_q.size() > 0) begin
            in_beat_out <= tx_q.pop_front();
            in_valid_out <= 1'b1;
         end else begin
            // Idle data is inverted each idle cycle, so a stale word can pass for a real one only on every second idle cycle.
            in_valid_out <= 1'b0;
            in_beat_out <= ~in_beat_out;
         end
      end
   end
endmodule

// ==== verification/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gtc_pkg::*;

   typedef logic [15:0] gtc_q_t[$];
   localparam logic [3:0] CTLS [8] = '{4'h0, 4'h7, 4'hf, 4'h8, 4'h1, 4'h2, 4'h4, 4'h6};

   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   gtc_apb_req_s req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, pl_in_ready, tn_ov, tn_or, tn_iv, tn_ir, pl_ov;
   logic pl_valid = 1'b0;
   logic pl_ready = 1'b0;
   logic stall = 1'b0;
   gtc_beat_s pl_beat = '0;
   gtc_beat_s tn_ob, tn_ib;
   gtc_rx_beat_s pl_ob;
   gtc_rx_beat_s pout[$];
   gtc_rx_beat_s exo[$];
   logic [15:0] seed = 16'hd543;
   logic [15:0] rnd = 16'hd543;
   logic [31:0] v [9];
   logic [31:0] tseq = 32'h0;
   int n_mismatch = 0;
   int check_count = 0;

   gtc_gre_codec dut (
      .sys_clk_in(sys_clk), .reset_n_in(reset_n), .apb_req_in(req), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .pl_in_valid_in(pl_valid),
      .pl_in_beat_in(pl_beat), .pl_in_ready_out(pl_in_ready), .tn_out_valid_out(tn_ov),
      .tn_out_beat_out(tn_ob), .tn_out_ready_in(tn_or), .tn_in_valid_in(tn_iv),
      .tn_in_beat_in(tn_ib), .tn_in_ready_out(tn_ir), .pl_out_valid_out(pl_ov),
      .pl_out_beat_out(pl_ob), .pl_out_ready_in(pl_ready));

   gtc_peer peer (
      .sys_clk_in(sys_clk), .reset_n_in(reset_n), .stall_in(stall), .out_valid_in(tn_ov),
      .out_beat_in(tn_ob), .out_ready_out(tn_or), .in_valid_out(tn_iv), .in_beat_out(tn_ib),
      .in_ready_in(tn_ir));

   ////////////////////////////////////////////////////////////////////////////
   always #12.5 sys_clk = ~sys_clk;

   // Back-pressure on both outputs keeps the hold-until-ready paths busy.
   always @(posedge sys_clk) begin
      rnd <= lfsr(rnd);
      stall <= rnd[0] & rnd[1];
      pl_ready <= rnd[2] | rnd[4];
      if (pl_ov && pl_ready) pout.push_back(pl_ob);
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Reference header builder; the checksum is recomputed here, not borrowed.
   function automatic gtc_q_t gre(input logic [15:0] w0, input logic [31:0] k,
                                  input logic [31:0] sq, input gtc_q_t p);
      gtc_q_t g;
      int s;
      g = {w0, 16'h0800};
      if (w0[15]) g = {g, 16'h0000, 16'h0000};
      if (w0[13]) g = {g, k[31:16], k[15:0]};
      if (w0[12]) g = {g, sq[31:16], sq[15:0]};
      g = {g, p};
      s = 0;
      foreach (g[i]) begin
         s = s + g[i];
         s = (s & 'hffff) + (s >> 16);
      end
      if (w0[15]) g[2] = ~s[15:0];
      return g;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic results;
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int t;
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (pready !== 1'b1 && t < 100);
      r = prdata;
      e = pslverr;
      req <= '0;
      @(posedge sys_clk);
      if (t >= 100) begin
         n_mismatch++;
         results();
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      chk({r[30:0], e}, {x[30:0], xe});
   endtask

   task automatic send(input gtc_q_t p);
      int t;
      foreach (p[i]) begin
         pl_valid <= 1'b1;
         pl_beat <= '{p[i], i == p.size() - 1};
         t = 0;
         do begin
            @(posedge sys_clk);
            t++;
         end while (pl_in_ready !== 1'b1 && t < 500);
         if (t >= 500) begin
            n_mismatch++;
            results();
         end
      end
      pl_valid <= 1'b0;
   endtask

   task automatic until_sz(input bit which, input int n);
      for (int i = 0; i < 3000; i++) begin
         if ((which ? pout.size() : peer.rx_q.size()) >= n) return;
         @(posedge sys_clk);
      end
      n_mismatch++;
      results();
   endtask

   task automatic dec(input logic [15:0] w0, input logic [31:0] sq, input int n,
                      input bit keep, input bit bad);
      gtc_q_t p, g;
      repeat (n) begin
         seed = lfsr(seed);
         p.push_back(seed);
      end
      g = gre(w0, v[2], sq, p);
      if (bad) g[2] = ~g[2];
      foreach (g[i]) peer.tx_q.push_back('{g[i], i == g.size() - 1});
      if (keep) foreach (p[i]) exo.push_back('{p[i], i == n - 1, bad && i == n - 1});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic e;
      gtc_q_t p, exq;
      logic [3:0] ctl;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rchk(OFS_ETYPE, 32'h0000_0800, 1'b0);
      rchk(8'h30, 32'h0, 1'b1);
      rchk(8'h06, 32'h0, 1'b1);
      apb(OFS_TX_SEQ, 1'b1, 32'h55, r, e);
      rchk(OFS_TX_SEQ, 32'h0, 1'b0);
      for (int i = 2; i < 9; i++) begin
         v[i] = {lfsr(seed), lfsr(lfsr(seed))};
         seed = v[i][15:0];
         apb(8'(i * 4), 1'b1, v[i], r, e);
      end
      foreach (CTLS[j]) begin
         ctl = CTLS[j];
         apb(OFS_CTRL, 1'b1, {28'h0, ctl}, r, e);
         p = {};
         repeat (1 + seed % 4) begin
            seed = lfsr(seed);
            p.push_back(seed);
         end
         exq = {v[3][15:0], v[4][31:16], v[4][15:0], v[5][31:16], v[5][15:0]};
         if (ctl[3]) for (int i = 6; i < 9; i++) exq = {exq, v[i][31:16], v[i][15:0]};
         exq = {exq, gre({ctl[0], 1'b0, ctl[1], ctl[2], 12'h000}, v[2], tseq, p)};
         if (ctl[2]) tseq++;
         send(p);
         until_sz(1'b0, exq.size());
         foreach (exq[i]) chk({15'h0, peer.rx_q[i]}, {15'h0, exq[i], i == exq.size() - 1});
         peer.rx_q.delete();
      end
      rchk(OFS_TX_SEQ, tseq, 1'b0);
      apb(OFS_CTRL, 1'b1, 32'h0, r, e);
      // Key and sequence flags fall inside the checked bits, so outside legacy
      // mode only a header without key or sequence flags may pass.
      dec(16'h7000, 32'h1, 2, 1'b0, 1'b0);
      dec(16'h8000, 32'h0, 3, 1'b1, 1'b0);
      until_sz(1'b1, exo.size());
      apb(OFS_CTRL, 1'b1, 32'h10, r, e);
      dec(16'h3000, 32'h0, 2, 1'b1, 1'b0);
      dec(16'h3001, 32'h1, 2, 1'b0, 1'b0);
      dec(16'h3000, 32'h0, 2, 1'b0, 1'b0);
      dec(16'h3000, 32'h1, 2, 1'b1, 1'b0);
      dec(16'h7000, 32'h2, 1, 1'b1, 1'b0);
      dec(16'hb000, 32'h3, 2, 1'b1, 1'b1);
      until_sz(1'b1, exo.size());
      foreach (exo[i]) chk({14'h0, pout[i].data, pout[i].last, pout[i].err & pout[i].last},
                           {14'h0, exo[i]});
      rchk(OFS_RX_DROP, 32'h3, 1'b0);
      rchk(OFS_RX_EXP, 32'h4, 1'b0);
      results();
   end
endmodule
